/* File: rcp_pkg.sv */
/*
  shared constants and types for the remote command processor:
  register offsets, character codes, status bit positions, timing.
  assumes a 50 MHz system clock and byte-addressed 32-bit registers.
*/
package rcp_pkg;
  // timing
  localparam int CLK_NS = 20;
  localparam int SETTLE_NS = 1000; // hardware settling time after an apply
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_IN = 8'h04;
  localparam logic [7:0] A_OUT = 8'h08;
  localparam logic [7:0] A_ERRQ = 8'h0c;
  localparam logic [7:0] A_STB = 8'h10;
  localparam logic [7:0] A_SRE = 8'h14;
  localparam logic [7:0] A_ESR = 8'h18;
  localparam logic [7:0] A_ESE = 8'h1c;
  localparam logic [7:0] A_PRE = 8'h20;
  localparam logic [7:0] A_HWSET = 8'h24;
  // control register bits (write pulses)
  localparam int CTRL_DCL = 0;
  localparam int CTRL_TALK = 1;
  // character codes of the command stream
  localparam logic [7:0] CH_TERM = 8'h0a;
  localparam logic [7:0] CH_SEP = 8'h3b;
  localparam logic [7:0] OP_SETA = 8'h41;
  localparam logic [7:0] OP_SETB = 8'h42;
  localparam logic [7:0] OP_GET = 8'h47;
  localparam logic [7:0] OP_OPC = 8'h4f;
  localparam logic [7:0] OP_OPCQ = 8'h51;
  localparam logic [7:0] OP_WAI = 8'h57;
  localparam logic [7:0] CH_ONE = 8'h31;
  // parameter range and mutual compatibility limits
  localparam logic [7:0] PAR_MAX = 8'hc8;
  localparam logic [8:0] SUM_MAX = 9'h12c;
  localparam logic [7:0] HW_A_RST = 8'h00;
  localparam logic [7:0] HW_B_RST = 8'h00;
  // error queue codes
  localparam logic [7:0] ERR_SYN = 8'h01;
  localparam logic [7:0] ERR_RNG = 8'h02;
  localparam logic [7:0] ERR_EXE = 8'h03;
  localparam logic [7:0] ERR_QRY = 8'h04;
  // event status bit positions
  localparam int ESR_OPC = 0;
  localparam int ESR_QRY = 2;
  localparam int ESR_RNG = 3;
  localparam int ESR_EXE = 4;
  localparam int ESR_SYN = 5;
  // status byte bit positions
  localparam int STB_EAV = 2;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_MSS = 6;
  // latched ahb address phase
  typedef struct packed {
    logic act;
    logic wr;
    logic [7:0] addr;
  } rcp_aph_t;
  typedef enum logic [1:0] {R_OP, R_VAL, R_SKIP, R_HOLD} rcp_st_t;
endpackage

/* File: rcp_top.sv */
/*
  remote command processor: input buffer, recognizer, data set with
  deferred hardware apply, synchronisation, output buffer, error queue
  and the top of the status hierarchy, all behind an ahb-lite slave.
  assumes a single ahb master, single word transfers, power-of-two depths.
*/
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// RL1: release buffered characters on full, terminator, clear
// RL2: full buffer stalls bus until drained; code stalls only until the recognizer takes one character
// RL3: keep accepting characters after a terminator
// RL4: device clear empties buffer, resets recognizer
// RL5: strict arrival order; trigger waits earlier commands
// RL6: recognized settings go to data set only
// RL7: syntax error reported, skip to next command
// RL8: out-of-range values rejected after syntax check
// RL9: end of line requests apply, parsing continues
// RL10: hardware changes only on apply request
// RL11: incompatible settings: error, discard, keep hardware
// RL12: no error for mid-line inconsistent settings
// RL13: controller sends consistent complete lines
// RL14: talk with nothing pending gives query error
// RL15: operation complete sets event bit when idle
// RL16: opc query waits, then returns one
// RL17: wait command blocks until prior commands done
// RL18: controller uses separate lines or sync commands
// RL19: every error enters a readable error queue; code queues one error per cycle and drops new errors when full
// RL20: status byte summarises masked event status
// RL21: individual status flag masked by poll enable
// RL22: output buffer occupancy drives message available
// RL23: status bit 4 set while message readable
// RL24: service request on enabled rising status bit
// RL25: service request enable bit 6 ignored
// RL26: individual flag ors all enabled bits, 6 included
// RL27: one byte per write, order preserved
module rcp_top import rcp_pkg::*; #(
  parameter int IBUF_DEPTH = 8,
  parameter int OBUF_DEPTH = 4,
  parameter int EQ_DEPTH = 4
)(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // instrument hardware
  output logic [7:0] hw_a_out,
  output logic [7:0] hw_b_out,
  output logic hw_busy_out,
  output logic trig_out,
  // status summary lines
  output logic srq_out,
  output logic ist_out
);
  localparam int IBW = $clog2(IBUF_DEPTH);
  localparam int IBC = $clog2(IBUF_DEPTH + 1);
  localparam int OBW = $clog2(OBUF_DEPTH);
  localparam int OBC = $clog2(OBUF_DEPTH + 1);
  localparam int EQW = $clog2(EQ_DEPTH);
  localparam int EQC = $clog2(EQ_DEPTH + 1);
  localparam int STW = $clog2(SETTLE_CYC + 1);

  rcp_aph_t dp_q;
  logic ap_ok, rd_ev, wr_fire, dcl_ev, talk_ev;
  logic [7:0] ra;
  logic [31:0] hrdata_q;
  logic [7:0] ib_mem [IBUF_DEPTH];
  logic [IBW-1:0] ib_wp_q, ib_rp_q;
  logic [IBC-1:0] ib_cnt_q, ib_rel_q;
  logic ib_push, ib_full, avail;
  logic [7:0] ch;
  rcp_st_t st_q;
  logic sel_b_q, qry_q, rec_take, syn_err, rng_err, set_ev, term_ev, get_ev, opc_ev;
  logic hw_idle, qry_done, opc_pend_q, opc_fire;
  logic [7:0] sh_a_q, sh_b_q, hw_a_q, hw_b_q;
  logic ap_pend_q, ap_start, compat, exe_err, qry_err;
  logic [STW-1:0] settle_q;
  logic [7:0] ob_mem [OBUF_DEPTH];
  logic [OBW-1:0] ob_wp_q, ob_rp_q;
  logic [OBC-1:0] ob_cnt_q;
  logic ob_pop, ob_empty, ob_full;
  logic [7:0] eq_mem [EQ_DEPTH];
  logic [EQW-1:0] eq_wp_q, eq_rp_q;
  logic [EQC-1:0] eq_cnt_q;
  logic eq_pop, eq_push, eq_empty;
  logic [7:0] eq_code;
  logic [7:0] esr_q, ese_q, sre_q, pre_q, stb_lo, stb, stb_prev_q, esr_set;
  logic stb_rd, esr_rd, mss, srq_q, trig_q;

  // address phase capture; reads act here so data leaves a flip-flop
  assign ap_ok = hsel_in & htrans_in[1] & hready_in;
  assign rd_ev = ap_ok & ~hwrite_in;
  assign ra = haddr_in[7:0];
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dp_q <= '0;
    end else if (hready_in) begin
      dp_q <= '{act: ap_ok, wr: hwrite_in, addr: haddr_in[7:0]};
    end
  end
  // a character write waits in its data phase while the buffer is full
  assign hreadyout_out = !(dp_q.act & dp_q.wr & (dp_q.addr == A_IN) & ib_full); // RL2
  assign hresp_out = 1'b0;
  assign wr_fire = dp_q.act & dp_q.wr & hreadyout_out;
  assign dcl_ev = wr_fire & (dp_q.addr == A_CTRL) & hwdata_in[CTRL_DCL];
  assign talk_ev = wr_fire & (dp_q.addr == A_CTRL) & hwdata_in[CTRL_TALK];
  assign ob_pop = rd_ev & (ra == A_OUT) & !ob_empty;
  assign eq_pop = rd_ev & (ra == A_ERRQ) & !eq_empty;
  assign stb_rd = rd_ev & (ra == A_STB);
  assign esr_rd = rd_ev & (ra == A_ESR);

  // read data register; unmapped offsets read zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hrdata_q <= '0;
    end else if (rd_ev) begin
      unique case (ra)
        A_CTRL: hrdata_q <= 32'({st_q == R_HOLD, ap_pend_q, hw_busy_out});
        A_IN: hrdata_q <= 32'(ib_cnt_q);
        A_OUT: hrdata_q <= ob_empty ? 32'h0 : 32'({1'b1, ob_mem[ob_rp_q]}); // an empty buffer never shows stale memory
        A_ERRQ: hrdata_q <= eq_empty ? 32'h0 : 32'(eq_mem[eq_rp_q]); // RL19
        A_STB: hrdata_q <= 32'(stb);
        A_SRE: hrdata_q <= 32'(sre_q);
        A_ESR: hrdata_q <= 32'(esr_q);
        A_ESE: hrdata_q <= 32'(ese_q);
        A_PRE: hrdata_q <= 32'(pre_q);
        A_HWSET: hrdata_q <= 32'({hw_b_q, hw_a_q});
        default: hrdata_q <= 32'h0;
      endcase
    end
  end
  assign hrdata_out = hrdata_q;

  // mask registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sre_q <= '0;
      ese_q <= '0;
      pre_q <= '0;
    end else if (wr_fire) begin
      if (dp_q.addr == A_SRE) sre_q <= hwdata_in[7:0];
      if (dp_q.addr == A_ESE) ese_q <= hwdata_in[7:0];
      if (dp_q.addr == A_PRE) pre_q <= hwdata_in[7:0];
    end
  end

  // input buffer: one byte per write, released for recognition in order
  assign ib_push = wr_fire & (dp_q.addr == A_IN); // RL27
  assign ib_full = ib_cnt_q == IBC'(IBUF_DEPTH);
  assign avail = ib_rel_q != '0;
  assign ch = ib_mem[ib_rp_q];
  always_ff @(posedge clk_in) begin
    if (ib_push) ib_mem[ib_wp_q] <= hwdata_in[7:0];
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || dcl_ev) begin // RL4
      ib_wp_q <= '0;
      ib_rp_q <= '0;
      ib_cnt_q <= '0;
      ib_rel_q <= '0;
    end else begin
      ib_wp_q <= ib_wp_q + IBW'(ib_push); // RL3
      ib_rp_q <= ib_rp_q + IBW'(rec_take); // RL5
      ib_cnt_q <= ib_cnt_q + IBC'(ib_push) - IBC'(rec_take);
      // a terminator or a filling write releases everything held
      if (ib_push && (hwdata_in[7:0] == CH_TERM || ib_cnt_q == IBC'(IBUF_DEPTH - 1))) begin // RL1
        ib_rel_q <= ib_cnt_q + 1'b1 - IBC'(rec_take);
      end else begin
        ib_rel_q <= ib_rel_q - IBC'(rec_take);
      end
    end
  end

  // recognizer decode; settings freeze while an apply is still queued
  assign hw_idle = !hw_busy_out && !ap_pend_q;
  always_comb begin
    rec_take = 1'b0;
    syn_err = 1'b0;
    rng_err = 1'b0;
    set_ev = 1'b0;
    term_ev = 1'b0;
    get_ev = 1'b0;
    opc_ev = 1'b0;
    unique case (st_q)
      R_OP: begin
        if (avail) begin
          if (ch == CH_TERM) begin
            rec_take = !ap_pend_q;
            term_ev = !ap_pend_q; // RL9
          end else if (ch == OP_GET) begin
            rec_take = hw_idle; // RL5
            get_ev = hw_idle;
          end else if (ch == OP_OPC) begin
            rec_take = 1'b1;
            opc_ev = 1'b1;
          end else if (ch == CH_SEP || ch == OP_SETA || ch == OP_SETB || ch == OP_WAI || ch == OP_OPCQ) begin
            rec_take = 1'b1;
          end else begin
            rec_take = 1'b1;
            syn_err = 1'b1; // RL7
          end
        end
      end
      R_VAL: begin
        if (avail && !ap_pend_q) begin
          rec_take = 1'b1;
          rng_err = ch > PAR_MAX; // RL8
          set_ev = ch <= PAR_MAX; // RL6
        end
      end
      R_SKIP: rec_take = avail && ch != CH_TERM;
      R_HOLD: rec_take = 1'b0; // RL17
    endcase
  end
  assign qry_done = st_q == R_HOLD && qry_q && hw_idle && !ob_full; // RL16

  // recognizer state; device clear overrides everything
  always_ff @(posedge clk_in) begin
    if (rst_in || dcl_ev) begin
      st_q <= R_OP;
      sel_b_q <= 1'b0;
      qry_q <= 1'b0;
    end else begin
      unique case (st_q)
        R_OP: begin
          if (rec_take && (ch == OP_SETA || ch == OP_SETB)) begin
            st_q <= R_VAL;
            sel_b_q <= ch == OP_SETB;
          end else if (rec_take && (ch == OP_WAI || ch == OP_OPCQ)) begin
            st_q <= R_HOLD;
            qry_q <= ch == OP_OPCQ;
          end else if (syn_err) begin
            st_q <= R_SKIP; // RL7
          end
        end
        R_VAL: if (rec_take) st_q <= R_OP;
        R_SKIP: if (avail && (ch == CH_SEP || ch == CH_TERM)) st_q <= R_OP;
        R_HOLD: if (hw_idle && (!qry_q || !ob_full)) st_q <= R_OP; // RL17
      endcase
    end
  end

  // data set: new values wait here until the end of the line
  assign compat = ({1'b0, sh_a_q} + {1'b0, sh_b_q}) <= SUM_MAX; // RL12
  assign ap_start = ap_pend_q && !hw_busy_out;
  assign exe_err = ap_start && !compat; // RL11
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sh_a_q <= HW_A_RST;
      sh_b_q <= HW_B_RST;
    end else if (exe_err) begin
      sh_a_q <= hw_a_q; // RL11
      sh_b_q <= hw_b_q;
    end else if (set_ev) begin
      if (sel_b_q) sh_b_q <= ch;
      else sh_a_q <= ch;
    end
  end
  // apply request: one may be queued behind a settling hardware update
  always_ff @(posedge clk_in) begin
    if (rst_in) ap_pend_q <= 1'b0;
    else ap_pend_q <= term_ev | dcl_ev | (ap_pend_q & !ap_start); // RL9
  end
  // hardware registers change only on an accepted apply
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hw_a_q <= HW_A_RST;
      hw_b_q <= HW_B_RST;
      settle_q <= '0;
    end else if (ap_start) begin
      if (compat) begin
        hw_a_q <= sh_a_q; // RL10
        hw_b_q <= sh_b_q;
        settle_q <= STW'(SETTLE_CYC);
      end
    end else if (settle_q != '0) begin
      settle_q <= settle_q - 1'b1;
    end
  end
  assign hw_a_out = hw_a_q;
  assign hw_b_out = hw_b_q;
  assign hw_busy_out = settle_q != '0;

  // trigger pulse and pending operation complete
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trig_q <= 1'b0;
      opc_pend_q <= 1'b0;
    end else begin
      trig_q <= get_ev;
      opc_pend_q <= !dcl_ev && (opc_ev || (opc_pend_q && !opc_fire));
    end
  end
  assign opc_fire = opc_pend_q && hw_idle; // RL15
  assign trig_out = trig_q;

  // output buffer; contents read through the out register
  assign ob_empty = ob_cnt_q == '0;
  assign ob_full = ob_cnt_q == OBC'(OBUF_DEPTH);
  always_ff @(posedge clk_in) begin
    if (qry_done) ob_mem[ob_wp_q] <= CH_ONE; // RL16
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || dcl_ev) begin
      ob_wp_q <= '0;
      ob_rp_q <= '0;
      ob_cnt_q <= '0;
    end else begin
      ob_wp_q <= ob_wp_q + OBW'(qry_done);
      ob_rp_q <= ob_rp_q + OBW'(ob_pop);
      ob_cnt_q <= ob_cnt_q + OBC'(qry_done) - OBC'(ob_pop);
    end
  end
  // talker addressed with nothing to say: error, bus stays silent
  assign qry_err = talk_ev && ob_empty && !(st_q == R_HOLD && qry_q); // RL14

  // error queue: one entry per cycle, new errors dropped when full
  always_comb begin
    eq_code = ERR_RNG;
    if (exe_err) eq_code = ERR_EXE;
    else if (qry_err) eq_code = ERR_QRY;
    else if (syn_err) eq_code = ERR_SYN;
  end
  assign eq_empty = eq_cnt_q == '0;
  assign eq_push = (exe_err | qry_err | syn_err | rng_err) && eq_cnt_q != EQC'(EQ_DEPTH); // RL19
  always_ff @(posedge clk_in) begin
    if (eq_push) eq_mem[eq_wp_q] <= eq_code;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      eq_wp_q <= '0;
      eq_rp_q <= '0;
      eq_cnt_q <= '0;
    end else begin
      eq_wp_q <= eq_wp_q + EQW'(eq_push);
      eq_rp_q <= eq_rp_q + EQW'(eq_pop);
      eq_cnt_q <= eq_cnt_q + EQC'(eq_push) - EQC'(eq_pop);
    end
  end

  // event status: read clears, a new event in that cycle survives
  always_comb begin
    esr_set = '0;
    esr_set[ESR_OPC] = opc_fire | qry_done; // RL15
    esr_set[ESR_QRY] = qry_err;
    esr_set[ESR_RNG] = rng_err;
    esr_set[ESR_EXE] = exe_err;
    esr_set[ESR_SYN] = syn_err;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) esr_q <= '0;
    else esr_q <= (esr_rd ? 8'h00 : esr_q) | esr_set;
  end

  // status byte; the summary bit never feeds its own mask
  always_comb begin
    stb_lo = '0;
    stb_lo[STB_EAV] = !eq_empty;
    stb_lo[STB_MAV] = !ob_empty; // RL22 RL23
    stb_lo[STB_ESB] = |(esr_q & ese_q); // RL20
  end
  assign mss = |(stb_lo & sre_q); // RL25
  assign stb = stb_lo | (8'(mss) << STB_MSS);
  assign ist_out = |(stb & pre_q); // RL21 RL26
  // service request latches on an enabled rising bit until polled
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stb_prev_q <= '0;
      srq_q <= 1'b0;
    end else begin
      stb_prev_q <= stb_lo;
      srq_q <= (|(stb_lo & ~stb_prev_q & sre_q)) | (srq_q & !stb_rd); // RL24
    end
  end
  assign srq_out = srq_q;

  a_full_stall: assert property (@(posedge clk_in) disable iff (rst_in) // RL2
    ib_full |=> ib_cnt_q <= IBC'(IBUF_DEPTH))
    else $error("character write accepted into a full buffer");
  a_term_release: assert property (@(posedge clk_in) disable iff (rst_in) // RL1
    (ib_push && hwdata_in[7:0] == CH_TERM && !dcl_ev) |=> ib_rel_q == ib_cnt_q)
    else $error("terminator did not release buffered characters");
  a_dcl_flush: assert property (@(posedge clk_in) disable iff (rst_in) // RL4
    dcl_ev |=> ib_cnt_q == '0 && st_q == R_OP && ap_pend_q)
    else $error("device clear left buffer or recognizer busy");
  a_hw_only_apply: assert property (@(posedge clk_in) disable iff (rst_in) // RL10
    !$past(ap_start) |-> $stable(hw_a_q) && $stable(hw_b_q))
    else $error("hardware changed without an apply");
  a_exe_discard: assert property (@(posedge clk_in) disable iff (rst_in) // RL11
    exe_err |=> $stable(hw_a_q) && sh_a_q == hw_a_q && sh_b_q == hw_b_q && esr_q[ESR_EXE])
    else $error("incompatible apply not discarded");
  a_wai_block: assert property (@(posedge clk_in) disable iff (rst_in) // RL17
    (st_q == R_HOLD && !hw_idle) |-> !rec_take ##1 st_q == R_HOLD)
    else $error("recognizer ran on before prior commands finished");
  a_opcq_answer: assert property (@(posedge clk_in) disable iff (rst_in || dcl_ev) // RL16
    qry_done |=> esr_q[ESR_OPC] && stb[STB_MAV] && st_q == R_OP)
    else $error("opc query answer missing");
  a_range_reject: assert property (@(posedge clk_in) disable iff (rst_in) // RL8
    (st_q == R_VAL && rec_take && ch > PAR_MAX) |=> $stable(sh_a_q) && $stable(sh_b_q) && esr_q[ESR_RNG])
    else $error("out of range value reached the data set");
  a_srq_rise: assert property (@(posedge clk_in) disable iff (rst_in) // RL24
    (|(stb_lo & ~stb_prev_q & sre_q)) |=> srq_out)
    else $error("enabled rising status bit gave no service request");
  a_query_err: assert property (@(posedge clk_in) disable iff (rst_in) // RL14
    (talk_ev && ob_empty && st_q != R_HOLD) |=> esr_q[ESR_QRY] && ob_empty)
    else $error("empty talk did not report a query error");
  a_in_order: assert property (@(posedge clk_in) disable iff (rst_in || dcl_ev) // RL27
    rec_take |=> ib_rp_q == $past(ib_rp_q) + 1'b1)
    else $error("characters consumed out of order");
endmodule

/* File: rcp_ctl.sv */
/*
  remote controller model: an ahb-lite master that writes command
  characters and reads registers of the command processor.
  assumes hready is the slave's hreadyout and tasks start just after a rising edge.
*/
`timescale 1ns/1ps
module rcp_ctl import rcp_pkg::*; (
  // clock
  input wire logic clk_in,
  // ahb-lite master side
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in
);
  // bus idles from time zero
  initial begin
    hsel_out = 1'b1;
    haddr_out = 32'h0;
    htrans_out = 2'b00;
    hwrite_out = 1'b0;
    hsize_out = 3'b010;
    hwdata_out = 32'h0;
  end

  // one single word transfer; ready is looked at before the edge to avoid races
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    logic ok;
    htrans_out <= 2'b10;
    haddr_out <= {24'h000000, a};
    hwrite_out <= w;
    do begin
      @(negedge clk_in);
      ok = hready_in;
      @(posedge clk_in);
    end while (ok !== 1'b1);
    htrans_out <= 2'b00;
    hwdata_out <= d;
    do begin
      @(negedge clk_in);
      ok = hready_in;
      r = hrdata_in;
      @(posedge clk_in);
    end while (ok !== 1'b1);
    hwdata_out <= ~d; // released data no longer shows the last value
  endtask

  // one command line, sent a character per word; caller keeps lines consistent
  task automatic send(input logic [7:0] s[], input logic term);
    logic [31:0] r;
    foreach (s[i]) xfer(1'b1, A_IN, {24'h000000, s[i]}, r);
    if (term) xfer(1'b1, A_IN, {24'h000000, CH_TERM}, r);
  endtask
endmodule

/* File: rcp_tb.sv */
/*
  self-checking bench for the remote command processor.
  assumes the controller model drives the bus and hready is looped back.
*/
`timescale 1ns/1ps
module tb import rcp_pkg::*;;
  logic clk_in, rst_in, hsel, hwrite, hreadyout, hresp, hw_busy, trig, srq, ist;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] hw_a, hw_b;
  int n_mismatch = 0, checks_done = 0, cyc = 0, n_stall = 0, n_trig = 0;
  logic trig_busy;

  rcp_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .hw_a_out(hw_a), .hw_b_out(hw_b), .hw_busy_out(hw_busy),
    .trig_out(trig), .srq_out(srq), .ist_out(ist));
  rcp_ctl i_ctl (.clk_in(clk_in), .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
    .hsize_out(hsize), .hwdata_out(hwdata), .hready_in(hreadyout), .hrdata_in(hrdata));

  // clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // monitors sample at the falling edge, where outputs are settled
  always @(negedge clk_in) begin
    cyc++;
    if (hreadyout === 1'b0) n_stall++;
    if (hresp !== 1'b0) begin
      n_mismatch++;
      $display("CHECK FAILED hresp expected 0 seen %b", hresp);
    end
    if (trig === 1'b1) begin
      n_trig++;
      trig_busy = hw_busy;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task rd(input logic [7:0] a, output logic [31:0] r);
    i_ctl.xfer(1'b0, a, 32'h0, r);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    i_ctl.xfer(1'b1, a, d, r);
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    rd(a, r);
    chk(nm, e, r);
  endtask

  // polls the input count and the control register; released characters not yet recognized show no busy flag
  task wait_idle;
    logic [31:0] r, c;
    int k;
    repeat (4) @(posedge clk_in);
    r = 32'h1;
    k = 0;
    while (r !== 32'h0 && k < 200) begin
      rd(A_IN, c);
      rd(A_CTRL, r);
      r = r | c;
      k++;
    end
    chk("idle", 32'h0, r);
  endtask

  task t_defer;
    rchk("stb_rst", A_STB, 32'h0);
    i_ctl.send('{OP_SETA, 8'h10, CH_SEP, OP_SETB, 8'h20}, 1'b0);
    rchk("hw_early", A_HWSET, 32'h0);
    wr(A_IN, {24'h0, CH_TERM});
    wait_idle();
    rchk("hw_apply", A_HWSET, 32'h2010);
    chk("hw_pins", 32'h2010, {16'h0, hw_b, hw_a});
  endtask

  task t_errors;
    i_ctl.send('{8'h58, CH_SEP, OP_SETA, 8'h05, OP_SETB, 8'hc9}, 1'b1);
    wait_idle();
    rchk("err_syn", A_ERRQ, {24'h0, ERR_SYN});
    rchk("err_rng", A_ERRQ, {24'h0, ERR_RNG});
    rchk("err_none", A_ERRQ, 32'h0);
    rchk("hw_after_err", A_HWSET, 32'h2005);
    i_ctl.send('{OP_SETA, 8'hc8, OP_SETB, 8'hc8}, 1'b1);
    wait_idle();
    rchk("err_exe", A_ERRQ, {24'h0, ERR_EXE});
    rchk("hw_kept", A_HWSET, 32'h2005);
    chk("hw_pins_kept", 32'h2005, {16'h0, hw_b, hw_a});
    i_ctl.send('{OP_SETA, 8'hc8, OP_SETB, 8'hc8, OP_SETB, 8'h10}, 1'b1);
    wait_idle();
    rchk("err_mid", A_ERRQ, 32'h0);
    rchk("hw_mid", A_HWSET, 32'h10c8);
  endtask

  task t_query;
    logic [31:0] r;
    rd(A_ESR, r);
    wr(A_CTRL, 32'h2);
    rchk("stb_eav", A_STB, 32'h4);
    rchk("err_qry", A_ERRQ, {24'h0, ERR_QRY});
    i_ctl.send('{OP_OPCQ}, 1'b1);
    wait_idle();
    rchk("stb_mav", A_STB, 32'h10);
    rchk("opcq_out", A_OUT, 32'h131);
    rchk("out_empty", A_OUT, 32'h0);
    rchk("esr_opc", A_ESR, 32'h5);
  endtask

  task t_status;
    logic [31:0] r;
    wr(A_ESE, 32'h1);
    wr(A_SRE, 32'h20);
    rd(A_STB, r);
    i_ctl.send('{OP_OPC}, 1'b1);
    wait_idle();
    @(negedge clk_in);
    chk("srq_opc", 32'h1, {31'h0, srq});
    @(posedge clk_in);
    rchk("stb_esb", A_STB, 32'h60);
    rchk("esr_clr", A_ESR, 32'h1);
    wr(A_SRE, 32'h40);
    rd(A_STB, r);
    i_ctl.send('{OP_OPC}, 1'b1);
    wait_idle();
    @(negedge clk_in);
    chk("srq_bit6", 32'h0, {31'h0, srq});
    @(posedge clk_in);
    wr(A_PRE, 32'h20);
    @(negedge clk_in);
    chk("ist_esb", 32'h1, {31'h0, ist});
    @(posedge clk_in);
    wr(A_PRE, 32'h40);
    @(negedge clk_in);
    chk("ist_off", 32'h0, {31'h0, ist});
    @(posedge clk_in);
    wr(A_SRE, 32'h20);
    @(negedge clk_in);
    chk("ist_mss", 32'h1, {31'h0, ist});
    @(posedge clk_in);
  endtask

  // the wait command stalls the recognizer during settling, so the buffer fills
  task t_stall;
    int n0;
    n0 = n_stall;
    i_ctl.send('{OP_SETA, 8'h01}, 1'b1);
    i_ctl.send('{OP_WAI, OP_SETA, 8'h02, OP_SETA, 8'h03, OP_SETA, 8'h04, OP_SETA, 8'h05}, 1'b1);
    wait_idle();
    chk("stalled", 32'h1, {31'h0, n_stall > n0});
    rchk("hw_order", A_HWSET, 32'h1005);
  endtask

  task t_sync;
    int n0;
    n0 = n_trig;
    i_ctl.send('{OP_SETA, 8'h22}, 1'b1);
    i_ctl.send('{OP_WAI, OP_GET}, 1'b1);
    wait_idle();
    chk("trig_cnt", n0 + 1, n_trig);
    chk("trig_busy", 32'h0, {31'h0, trig_busy});
    rchk("hw_sync", A_HWSET, 32'h1022);
  endtask

  task t_clear;
    i_ctl.send('{OP_SETA, 8'h44}, 1'b0);
    rchk("in_cnt", A_IN, 32'h2);
    wr(A_CTRL, 32'h1);
    rchk("in_clr", A_IN, 32'h0);
    wait_idle();
    rchk("hw_clr", A_HWSET, 32'h1022);
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_defer();
    t_errors();
    t_query();
    t_status();
    t_stall();
    t_sync();
    t_clear();
    tally_and_finish();
  end
endmodule
